// ===== src/bsmd_pkg.sv
// Constants, types and BCD helpers of the BCD subtract/multiply/divide unit.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit word memory port.
package bsmd_pkg;

	// ********************************
	// Register map and fields
	// ********************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_OPERAND = 8'h04;
	localparam logic [7:0] OFS_ACC     = 8'h08;
	localparam logic [7:0] OFS_STACK0  = 8'h0C;
	localparam logic [7:0] OFS_STACK1  = 8'h10;
	localparam logic [7:0] OFS_FLAGS   = 8'h14;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h1C;
	localparam int CTRL_START   = 0;
	localparam int CTRL_OP_LSB  = 4;
	localparam int CTRL_MD_LSB  = 8;
	localparam int CTRL_BUSY    = 16;
	localparam int FL_ZERO      = 0;
	localparam int FL_B16       = 1;
	localparam int FL_B32       = 2;
	localparam int FL_NEG       = 3;
	localparam int FL_NBCD      = 4;
	localparam int FL_OVF       = 5;
	localparam int IRQ_DONE     = 0;
	localparam int IRQ_NBCD     = 1;
	localparam int IRQ_OVF      = 2;
	localparam int IRQ_REJECT   = 3;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {
		OP_SUB32 = 2'h0, OP_MUL16 = 2'h1, OP_MUL32 = 2'h2, OP_DIV16 = 2'h3
	} bsmd_op_t;
	typedef enum logic [1:0] {
		MD_DIRECT = 2'h0, MD_POINTER = 2'h1, MD_IMMED = 2'h2, MD_BAD = 2'h3
	} bsmd_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_PTR = 3'h1, ST_FLO = 3'h3, ST_FHI = 3'h2,
		ST_CHECK = 3'h6, ST_MUL = 3'h7, ST_DIV = 3'h5, ST_DONE = 3'h4
	} bsmd_state_t;
	typedef enum logic [3:0] {
		R_CTRL, R_OPERAND, R_ACC, R_STACK0, R_STACK1, R_FLAGS, R_IRQ_ST,
		R_IRQ_MSK, R_NONE
	} bsmd_reg_t;

	// ********************************
	// BCD helpers, sixteen digits wide; bcd_ok checks eight
	// ********************************
	function automatic logic [63:0] bcd_add(input logic [63:0] a,
		input logic [63:0] b);
		logic [4:0]  d;
		logic        c;
		logic [63:0] r;
		c = 1'b0;
		r = 64'h0;
		for (int i = 0; i < 16; i++) begin
			d = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
			c = (d > 5'h09);
			r[4*i+:4] = c ? 4'(d[3:0] + 4'h6) : d[3:0];
		end
		return r;
	endfunction : bcd_add

	// Returns the borrow out above the ten's-complement difference.
	function automatic logic [64:0] bcd_sub(input logic [63:0] a,
		input logic [63:0] b);
		logic [4:0]  d;
		logic        w;
		logic [63:0] r;
		w = 1'b0;
		r = 64'h0;
		for (int i = 0; i < 16; i++) begin
			d = {1'b0, a[4*i+:4]} - {1'b0, b[4*i+:4]} - {4'h0, w};
			w = d[4];
			r[4*i+:4] = w ? 4'(d[3:0] + 4'hA) : d[3:0];
		end
		return {w, r};
	endfunction : bcd_sub

	function automatic logic bcd_ok(input logic [31:0] x);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (x[4*i+:4] > 4'h9) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : bcd_ok

endpackage : bsmd_pkg

// ===== src/bsmd_unit.sv
// BCD subtract, multiply and divide unit with AXI4-Lite registers.
// Assumes a word memory that answers a held mem_req with a one-cycle mem_ack.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module bsmd_unit #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   mem_req,
	output logic [15:0]            mem_addr,
	input  wire logic              mem_ack,
	input  wire logic [15:0]       mem_rdata,
	output logic                   irq,
	output logic                   zero_result_flag,
	output logic                   borrow16_flag,
	output logic                   borrow32_flag,
	output logic                   negative_result_flag,
	output logic                   non_bcd_error_flag,
	output logic                   operand_overflow_flag,
	output bsmd_pkg::bsmd_state_t  state
);
	import bsmd_pkg::*;

	function automatic bsmd_reg_t reg_of(input logic [ADDR_W-1:0] a);
		bsmd_reg_t r;
		r = R_NONE;
		if (a[ADDR_W-1:5] == '0 && a[1:0] == 2'h0) begin
			unique case ({3'h0, a[4:0]})
				OFS_CTRL:    r = R_CTRL;
				OFS_OPERAND: r = R_OPERAND;
				OFS_ACC:     r = R_ACC;
				OFS_STACK0:  r = R_STACK0;
				OFS_STACK1:  r = R_STACK1;
				OFS_FLAGS:   r = R_FLAGS;
				OFS_IRQ_ST:  r = R_IRQ_ST;
				OFS_IRQ_MSK: r = R_IRQ_MSK;
				default:     r = R_NONE;
			endcase
		end
		return r;
	endfunction : reg_of

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i+:8] = d[8*i+:8];
			end
		end
		return r;
	endfunction : merge

	// ********************************
	// Bus slave
	// ********************************
	logic              aw_held, w_held;
	logic [ADDR_W-1:0] aw_a;
	logic [31:0]       w_d;
	logic [3:0]        w_s;
	logic              next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [ADDR_W-1:0] next_aw_a;
	logic [31:0]       next_w_d, next_rdata;
	logic [3:0]        next_w_s;
	logic [1:0]        next_bresp, next_rresp;
	logic              wr_do;
	bsmd_reg_t         wr_reg, rd_reg;
	bsmd_op_t          op;
	bsmd_mode_t        mode;
	logic [31:0]       opnd, acc, stk0, stk1, val;
	logic [63:0]       work;
	logic [5:0]        flags;
	logic [3:0]        irq_st, irq_msk;

	assign awready = !aw_held;
	assign wready  = !w_held;
	assign arready = !rvalid;
	assign wr_do   = aw_held && w_held && !bvalid;
	assign wr_reg  = reg_of(aw_a);
	assign rd_reg  = reg_of(araddr);

	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_a    = aw_a;
		next_w_d     = w_d;
		next_w_s     = w_s;
		next_bvalid  = bvalid && !bready;
		next_bresp   = bresp;
		next_rvalid  = rvalid && !rready;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_a    = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_d    = wdata;
			next_w_s    = wstrb;
		end
		if (wr_do) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (wr_reg == R_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp  = (rd_reg == R_NONE) ? RESP_SLVERR : RESP_OKAY;
			unique case (rd_reg)
				R_CTRL: begin
					next_rdata = RST_WORD;
					next_rdata[CTRL_OP_LSB+:2] = op;
					next_rdata[CTRL_MD_LSB+:2] = mode;
					next_rdata[CTRL_BUSY] = (state != ST_IDLE);
				end
				R_OPERAND: next_rdata = opnd;
				R_ACC:     next_rdata = acc;
				R_STACK0:  next_rdata = stk0;
				R_STACK1:  next_rdata = stk1;
				R_FLAGS:   next_rdata = {26'h0, flags};
				R_IRQ_ST:  next_rdata = {28'h0, irq_st};
				R_IRQ_MSK: next_rdata = {28'h0, irq_msk};
				R_NONE:    next_rdata = RST_WORD;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_a    <= '0;
			w_d     <= RST_WORD;
			w_s     <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= RST_WORD;
			rresp   <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			aw_a    <= next_aw_a;
			w_d     <= next_w_d;
			w_s     <= next_w_s;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ********************************
	// Operand fetch and arithmetic engine
	// ********************************
	bsmd_state_t next_state;
	bsmd_op_t    next_op;
	bsmd_mode_t  next_mode;
	logic [31:0] next_opnd, next_acc, next_stk0, next_stk1, next_val;
	logic [63:0] next_work, mcand;
	logic [5:0]  next_flags;
	logic [3:0]  next_irq_st, next_irq_msk, rep, next_rep;
	logic [2:0]  idx, next_idx;
	logic        phase, bad, ovf, bw16, bw32, bad_now;
	logic        next_phase, next_bad, next_ovf, next_bw16, next_bw32;
	logic        next_mem_req, start, lo_lt, full_lt;
	logic [15:0] next_mem_addr;
	logic [64:0] s32, s16, sdiv;
	logic [31:0] res;
	bsmd_op_t    req_op;
	bsmd_mode_t  req_md;

	assign start = wr_do && wr_reg == R_CTRL && w_s[0] && w_d[CTRL_START];
	assign req_op = bsmd_op_t'(w_d[CTRL_OP_LSB+:2]);
	assign req_md = bsmd_mode_t'(w_d[CTRL_MD_LSB+:2]);
	assign mcand = (op == OP_MUL16) ? {48'h0, acc[15:0]} : {32'h0, acc};
	assign s32   = bcd_sub({32'h0, acc}, {32'h0, val});
	assign s16   = bcd_sub({48'h0, acc[15:0]}, {48'h0, val[15:0]});
	assign sdiv  = bcd_sub({40'h0, work[23:0]}, {48'h0, val[15:0]});
	assign lo_lt   = acc[15:0] < val[15:0];
	assign full_lt = acc < val;
	assign res   = (op == OP_DIV16) ? work[63:32] : work[31:0];
	assign irq   = |(irq_st & irq_msk);
	assign {operand_overflow_flag, non_bcd_error_flag, negative_result_flag,
		borrow32_flag, borrow16_flag, zero_result_flag} = flags;

	always_comb begin
		bad_now = 1'b0;
		unique case (op)
			OP_MUL16: bad_now = !bcd_ok({16'h0, acc[15:0]}) ||
				!bcd_ok({16'h0, val[15:0]});
			OP_DIV16: bad_now = !bcd_ok(acc) || !bcd_ok({16'h0, val[15:0]});
			default:  bad_now = !bcd_ok(acc) || !bcd_ok(val);
		endcase
	end

	always_comb begin
		next_state = state;
		next_op = op;
		next_mode = mode;
		next_opnd = opnd;
		next_acc = acc;
		next_stk0 = stk0;
		next_stk1 = stk1;
		next_val = val;
		next_work = work;
		next_flags = flags;
		next_irq_msk = irq_msk;
		next_irq_st = irq_st;
		next_rep = rep;
		next_idx = idx;
		next_phase = phase;
		next_bad = bad;
		next_ovf = ovf;
		next_bw16 = bw16;
		next_bw32 = bw32;
		next_mem_req = mem_req;
		next_mem_addr = mem_addr;
		if (wr_do && wr_reg == R_IRQ_ST) begin
			next_irq_st = irq_st & ~w_d[3:0];
		end
		if (wr_do && wr_reg == R_IRQ_MSK && w_s[0]) begin
			next_irq_msk = w_d[3:0];
		end
		if (wr_do && state == ST_IDLE) begin
			unique case (wr_reg)
				R_OPERAND: next_opnd = merge(opnd, w_d, w_s);
				R_ACC:     next_acc = merge(acc, w_d, w_s);
				R_STACK0:  next_stk0 = merge(stk0, w_d, w_s);
				R_STACK1:  next_stk1 = merge(stk1, w_d, w_s);
				default:   next_acc = acc;
			endcase
		end
		unique case (state)
			ST_IDLE: begin
				if (start && (req_md == MD_BAD || (req_md == MD_IMMED &&
					req_op == OP_MUL32))) begin
					// A refused start touches nothing but its status bit.
					next_irq_st[IRQ_REJECT] = 1'b1;
				end else if (start) begin
					next_op = req_op;
					next_mode = req_md;
					next_bad = 1'b0;
					next_ovf = 1'b0;
					next_val = opnd;
					next_mem_addr = opnd[15:0];
					if (req_md == MD_IMMED) begin
						next_state = ST_CHECK;
					end else begin
						next_mem_req = 1'b1;
						next_state = (req_md == MD_POINTER) ? ST_PTR : ST_FLO;
					end
				end
			end
			ST_PTR: begin
				if (mem_ack) begin
					next_mem_addr = mem_rdata;
					next_state = ST_FLO;
				end
			end
			ST_FLO: begin
				if (mem_ack) begin
					next_val = {16'h0, mem_rdata};
					if (op == OP_SUB32 || op == OP_MUL32) begin
						next_mem_addr = 16'(mem_addr + 16'h0001);
						next_state = ST_FHI;
					end else begin
						next_mem_req = 1'b0;
						next_state = ST_CHECK;
					end
				end
			end
			ST_FHI: begin
				if (mem_ack) begin
					next_val[31:16] = mem_rdata;
					next_mem_req = 1'b0;
					next_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				next_work = 64'h0;
				next_phase = 1'b0;
				next_idx = (op == OP_MUL16) ? 3'h3 : 3'h7;
				next_state = ST_DONE;
				if (bad_now) begin
					next_bad = 1'b1;
				end else if (op == OP_DIV16 && val[15:0] == 16'h0) begin
					next_ovf = 1'b1;
				end else if (op == OP_SUB32) begin
					next_work[31:0] = s32[31:0];
					next_bw32 = s32[64];
					next_bw16 = s16[64];
				end else begin
					next_state = (op == OP_DIV16) ? ST_DIV : ST_MUL;
				end
			end
			ST_MUL: begin
				// Shift-and-add, one multiplier digit from the top at a time.
				if (!phase) begin
					next_work = {work[59:0], 4'h0};
					next_rep = val[4*idx+:4];
					next_phase = 1'b1;
				end else if (rep != 4'h0) begin
					next_work = bcd_add(work, mcand);
					next_rep = 4'(rep - 4'h1);
				end else if (idx == 3'h0) begin
					next_state = ST_DONE;
				end else begin
					next_idx = 3'(idx - 3'h1);
					next_phase = 1'b0;
				end
			end
			ST_DIV: begin
				// Remainder in the low digits, quotient built in the top word.
				if (!phase) begin
					next_work[23:0] = {work[19:0], acc[4*idx+:4]};
					next_rep = 4'h0;
					next_phase = 1'b1;
				end else if (work[23:0] >= {8'h00, val[15:0]}) begin
					next_work[23:0] = sdiv[23:0];
					next_rep = 4'(rep + 4'h1);
				end else begin
					next_work[63:32] = {work[59:32], rep};
					next_phase = 1'b0;
					next_idx = 3'(idx - 3'h1);
					next_state = (idx == 3'h0) ? ST_DONE : ST_DIV;
				end
			end
			ST_DONE: begin
				if (!bad && !ovf) begin
					next_acc = res;
					if (op == OP_MUL32) begin
						next_stk1 = stk0;
						next_stk0 = work[63:32];
					end
					if (op == OP_DIV16) begin
						next_stk0 = {8'h00, work[23:0]};
					end
				end
				next_flags[FL_ZERO] = ((bad || ovf) ? acc : res) == RST_WORD;
				next_flags[FL_NBCD] = bad;
				next_flags[FL_NEG] = op == OP_SUB32 && !bad && bw32;
				if (op == OP_SUB32) begin
					next_flags[FL_B16] = !bad && bw16;
					next_flags[FL_B32] = !bad && bw32;
				end
				if (op == OP_DIV16) begin
					next_flags[FL_OVF] = ovf;
				end
				next_irq_st[IRQ_DONE] = 1'b1;
				next_irq_st[IRQ_NBCD] = irq_st[IRQ_NBCD] | bad;
				next_irq_st[IRQ_OVF] = irq_st[IRQ_OVF] | ovf;
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			op <= OP_SUB32;
			mode <= MD_DIRECT;
			{opnd, acc, stk0, stk1, val} <= {5{RST_WORD}};
			work <= 64'h0;
			flags <= 6'h00;
			irq_st <= 4'h0;
			irq_msk <= 4'h0;
			rep <= 4'h0;
			idx <= 3'h0;
			{phase, bad, ovf, bw16, bw32, mem_req} <= 6'h00;
			mem_addr <= 16'h0000;
		end else begin
			state <= next_state;
			op <= next_op;
			mode <= next_mode;
			{opnd, acc, stk0, stk1, val} <=
				{next_opnd, next_acc, next_stk0, next_stk1, next_val};
			work <= next_work;
			flags <= next_flags;
			irq_st <= next_irq_st;
			irq_msk <= next_irq_msk;
			rep <= next_rep;
			idx <= next_idx;
			{phase, bad, ovf, bw16, bw32, mem_req} <=
				{next_phase, next_bad, next_ovf, next_bw16, next_bw32, next_mem_req};
			mem_addr <= next_mem_addr;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic dn, ok;
	assign dn = state == ST_DONE;
	assign ok = !bad && !ovf;
	property p_zero; dn |=> zero_result_flag == (acc == RST_WORD); endproperty
	property p_b16;
		dn && op == OP_SUB32 && ok |=> borrow16_flag == $past(lo_lt);
	endproperty
	property p_b32;
		dn && op == OP_SUB32 && ok |=> borrow32_flag == $past(full_lt)
			&& negative_result_flag == borrow32_flag;
	endproperty
	property p_neg; dn && op != OP_SUB32 |=> !negative_result_flag; endproperty
	property p_nbcd;
		state == ST_CHECK && bad_now |=> dn ##1 non_bcd_error_flag
			&& acc == $past(acc, 2);
	endproperty
	property p_div0;
		dn && op == OP_DIV16 && ovf |=> operand_overflow_flag
			&& acc == $past(acc) && stk0 == $past(stk0);
	endproperty
	property p_push; dn && op == OP_MUL32 && ok |=> stk1 == $past(stk0); endproperty
	property p_quot;
		dn && op == OP_DIV16 && ok |=> acc == $past(res)
			&& stk0 < {16'h0, val[15:0]};
	endproperty
	property p_mem; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	a_b16: assert property (p_b16) else $error("borrow16 wrong");
	a_b32: assert property (p_b32) else $error("borrow32 wrong");
	a_neg: assert property (p_neg) else $error("negative wrong");
	a_nbcd: assert property (p_nbcd) else $error("non-BCD missed");
	a_div0: assert property (p_div0) else $error("zero divide");
	a_push: assert property (p_push) else $error("no push");
	a_quot: assert property (p_quot) else $error("quotient lost");
	a_mem: assert property (p_mem) else $error("fetch dropped");
	c_sub: cover property (dn && op == OP_SUB32 && bw32);
	c_mul: cover property (dn && op == OP_MUL32 && ok);
	c_div: cover property (dn && op == OP_DIV16 && ok);
	c_ovf: cover property (dn && ovf);
	c_bad: cover property (dn && bad);

endmodule : bsmd_unit

// ===== test/bsmd_mem_model.sv
// Word memory model that answers the unit's operand reads.
// Assumes the unit holds mem_req and mem_addr until a one-cycle mem_ack.
`timescale 1ns/1ps
module bsmd_mem_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        mem_req,
	input  wire logic [15:0] mem_addr,
	input  wire logic [3:0]  lat,
	output logic             mem_ack,
	output logic [15:0]      mem_rdata
);
	logic [15:0] words [16];
	logic [3:0]  cnt;

	// Outside an answer the data lines invert every cycle, alternating the last word and its inverse.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_ack   <= 1'b0;
			mem_rdata <= 16'h0000;
			cnt       <= 4'h0;
		end else if (mem_req && !mem_ack && cnt == lat) begin
			mem_ack   <= 1'b1;
			mem_rdata <= words[mem_addr[3:0]];
			cnt       <= 4'h0;
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt       <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule : bsmd_mem_model

// ===== test/test_bcd_sub_mul_div_unit.sv
// Self-checking bench of the BCD unit, driven over AXI4-Lite.
// Assumes the word memory model and the unit's register map package.
`timescale 1ns/1ps
module test_bcd_sub_mul_div_unit;
	import bsmd_pkg::*;
	logic              aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic [31:0]       wdata = 32'h0, rdata, v;
	logic              awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]        bresp, rresp, resp;
	logic              mem_req, mem_ack;
	logic [15:0]       mem_addr, mem_rdata;
	logic [3:0]        lat = 4'h0;
	logic [5:0]        fl;
	bsmd_state_t       state;
	int                n_fail = 0, comparisons = 0;

	always #50 aclk = ~aclk;

	bsmd_unit dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.irq(irq), .zero_result_flag(fl[0]), .borrow16_flag(fl[1]),
		.borrow32_flag(fl[2]), .negative_result_flag(fl[3]),
		.non_bcd_error_flag(fl[4]), .operand_overflow_flag(fl[5]),
		.state(state));

	bsmd_mem_model mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
		.mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	// ********************************
	// Bus tasks and comparisons
	// ********************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid) @(posedge aclk);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge aclk);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	// Starts one operation and polls the sticky done bit.
	task automatic run(input logic [1:0] op, input logic [1:0] md,
		input logic [31:0] acc, input logic [31:0] opnd);
		wr(OFS_ACC, acc);
		wr(OFS_OPERAND, opnd);
		wr(OFS_IRQ_ST, 32'h0000_000F);
		wr(OFS_CTRL, {22'h0, md, 2'h0, op, 4'h1});
		v = 32'h0;
		for (int i = 0; i < 200 && v[IRQ_DONE] !== 1'b1; i++)
			rd(OFS_IRQ_ST, v);
	endtask : run

	task automatic res(input logic [31:0] acc, input logic [5:0] f);
		rd(OFS_ACC, v);
		chk("acc", acc, v);
		rd(OFS_FLAGS, v);
		chk("flags", {26'h0, f}, v);
		chk("flag pins", {26'h0, f}, {26'h0, fl});
		chk("state", {29'h0, ST_IDLE}, {29'h0, state});
	endtask : res

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	// ********************************
	// Tests
	// ********************************
	initial begin
		#(20000 * 100);
		n_fail++;
		wrap_up;
	end

	initial begin
		mem.words = '{default: 16'h0000};
		mem.words[2] = 16'h0001;
		mem.words[4] = 16'h0006;
		mem.words[6] = 16'h5678;
		mem.words[7] = 16'h1234;
		mem.words[8] = 16'h0100;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		res(32'h0, 6'h00);
		run(OP_SUB32, MD_DIRECT, 32'h0001_0000, 32'h2);
		res(32'h0000_9999, 6'h02);
		run(OP_SUB32, MD_IMMED, 32'h5, 32'h6);
		res(32'h9999_9999, 6'h0E);
		lat <= 4'h3;
		run(OP_SUB32, MD_POINTER, 32'h1234_5678, 32'h4);
		res(32'h0, 6'h01);
		lat <= 4'h0;
		run(OP_MUL16, MD_IMMED, 32'h1234_9999, 32'h9999);
		res(32'h9998_0001, 6'h00);
		wr(OFS_STACK0, 32'h77);
		run(OP_MUL32, MD_DIRECT, 32'h1234_5678, 32'h8);
		res(32'h3456_7800, 6'h00);
		rd(OFS_STACK0, v);
		chk("stack0", 32'h12, v);
		rd(OFS_STACK1, v);
		chk("stack1", 32'h77, v);
		run(OP_DIV16, MD_IMMED, 32'h1000, 32'h7);
		res(32'h142, 6'h00);
		rd(OFS_STACK0, v);
		chk("remainder", 32'h6, v);
		wr(OFS_IRQ_MSK, 32'h2);
		run(OP_SUB32, MD_IMMED, 32'hA, 32'h1);
		res(32'hA, 6'h10);
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_ST, 32'h2);
		@(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		run(OP_DIV16, MD_DIRECT, 32'h142, 32'hA);
		res(32'h142, 6'h20);
		rd(OFS_STACK0, v);
		chk("stack0 kept", 32'h6, v);
		run(OP_MUL32, MD_IMMED, 32'h142, 32'h1);
		chk("reject status", 32'h8, v);
		res(32'h142, 6'h20);
		wr(OFS_IRQ_ST, 32'h0000_000F);
		wr(OFS_CTRL, {22'h0, MD_BAD, 2'h0, OP_SUB32, 4'h1});
		rd(OFS_IRQ_ST, v);
		chk("bad mode reject", 32'h8, v);
		rd(OFS_CTRL, v);
		chk("ctrl kept", {26'h0, OP_DIV16, 4'h0}, v);
		wr(OFS_FLAGS, 32'h3F);
		res(32'h142, 6'h20);
		rd(8'h20, v);
		chk("unmapped read", 32'h0, v);
		chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wr(8'h24, 32'h1);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wrap_up;
	end
endmodule : test_bcd_sub_mul_div_unit
